// ===== rtl/rmp_pkg.sv
// Purpose: Shared constants for the region memory protection checker
// Assumes: AHB-Lite register window, one 32-bit word per register
// Notes:   Region size code N selects a span of 2^(N+1) bytes; codes below 4 select 32 bytes
package rmp_pkg;

	// Region count and register map (byte addresses)
	localparam int         RMP_NUM_REGIONS = 8;
	localparam logic [7:0] OFS_TYPE        = 8'h00;
	localparam logic [7:0] OFS_CTRL        = 8'h04;
	localparam logic [7:0] OFS_RNR         = 8'h08;
	localparam logic [7:0] OFS_RBAR        = 8'h0C;
	localparam logic [7:0] OFS_RASR        = 8'h10;
	localparam logic [7:0] OFS_FSTAT       = 8'h14;
	localparam logic [7:0] OFS_FADDR       = 8'h18;
	localparam logic [7:0] OFS_RENA        = 8'h1C;

	// Field positions
	localparam int TYPE_COUNT_LSB   = 8;
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int CTRL_HFNMI_BIT   = 1;
	localparam int CTRL_PRIVDEF_BIT = 2;
	localparam int RBAR_BASE_LSB    = 5;
	localparam int RASR_ENABLE_BIT  = 0;
	localparam int RASR_SIZE_LSB    = 1;
	localparam int RASR_SRD_LSB     = 8;
	localparam int RASR_AP_LSB      = 24;
	localparam int RASR_XN_BIT      = 28;
	localparam int FSTAT_VALID_BIT  = 0;
	localparam int FSTAT_FETCH_BIT  = 1;
	localparam int FSTAT_WRITE_BIT  = 2;
	localparam int FSTAT_PRIV_BIT   = 3;
	localparam int FSTAT_NOHIT_BIT  = 4;

	// Size codes: 4 is 32 bytes, 31 is 4 GB
	localparam logic [4:0] SIZE_MIN_CODE = 5'h04;

	// Access permission codes
	localparam logic [2:0] AP_NONE     = 3'h0;
	localparam logic [2:0] AP_PRW      = 3'h1;
	localparam logic [2:0] AP_PRW_URO  = 3'h2;
	localparam logic [2:0] AP_RW       = 3'h3;
	localparam logic [2:0] AP_PRO      = 3'h5;
	localparam logic [2:0] AP_RO       = 3'h6;
	localparam logic [2:0] AP_RO_ALT   = 3'h7;

	// Reset values
	localparam logic [2:0]  CTRL_RESET = 3'h0;
	localparam logic [26:0] BASE_RESET = 27'h0000000;
	localparam logic [4:0]  SIZE_RESET = 5'h04;
	localparam logic [7:0]  SRD_RESET  = 8'h00;
	localparam logic [2:0]  AP_RESET   = 3'h0;

endpackage

// ===== rtl/rmp_match_if.sv
// Purpose: Carries one region's settings and the access address to a matcher
// Assumes: Same clock domain on both sides, purely combinational signals
// Notes:   One instance per region
`timescale 1ns/1ps
interface rmp_match_if;
	logic [31:0] addr;
	logic [26:0] base;
	logic [4:0]  size_code;
	logic [7:0]  srd;
	logic        enable;
	logic        hit;

	modport region (input addr, input base, input size_code, input srd, input enable,
		output hit);
	modport owner (output addr, output base, output size_code, output srd,
		output enable, input hit);
endinterface

// ===== rtl/rmp_region_match.sv
// Purpose: Decides whether an address falls in one enabled region
// Assumes: Base low bits below the region size are ignored
// Notes:   Sizes below 32 bytes are clamped up to 32 bytes
`timescale 1ns/1ps
module rmp_region_match
	import rmp_pkg::*;
(
	// Region settings and address
	rmp_match_if.region m
);

	logic [4:0]  code_eff;
	logic [5:0]  span_sh;
	logic [31:0] diff;
	logic [31:0] far_bits;
	logic [31:0] sub_word;
	logic [2:0]  sub_idx;

	// Range compare, then sub-region veto
	always_comb begin
		code_eff = (m.size_code < SIZE_MIN_CODE) ? SIZE_MIN_CODE : m.size_code; // [R02]
		span_sh  = 6'(code_eff) + 6'h01;
		diff     = m.addr ^ {m.base, 5'h00};
		far_bits = (span_sh == 6'h20) ? 32'h00000000 : (diff >> span_sh);
		// Eighths of the span, lowest address first [R20]
		sub_word = m.addr >> (span_sh - 6'h03);
		sub_idx  = sub_word[2:0];
		m.hit    = m.enable && (far_bits == 32'h00000000) && !m.srd[sub_idx]; // [R06]
	end

endmodule

// ===== rtl/rmp_unit.sv
// Purpose: Region memory protection checker with an AHB-Lite register slave
// Assumes: Access requests arrive on CLOCK from core logic; single-word bus transfers
// Notes:   Verdict appears one cycle after the request; bus has no wait states
//
// Behaviour
// [R01] Up to eight programmable regions are supported.
// [R02] Region size is a power of two from 32 bytes to 4 GB.
// [R03] Software aligns each region base to the region size.
// [R04] Each region can forbid instruction fetches.
// [R05] Privileged and user data access each read-only, read/write or none.
// [R06] Each region has eight sub-regions that can each be disabled.
// [R07] With protection on, a permission violation raises a fault.
// [R08] Disabling a region keeps its base, size and attributes.
// [R09] Each region has its own enable bit among its attributes.
// [R10] Attribute readback includes the enable bit for later restore.
// [R11] Option lets privileged accesses outside regions use the default map.
// [R12] Protection on, no default map, no region enabled: accesses fault.
// [R13] Option makes hard fault and NMI handlers use or bypass regions.
// [R14] Global enable turns region checking on and off.
// [R15] Software defines regions before setting the global enable.
// [R16] Software disables a region before reprogramming it.
// [R17] With protection off, the default map applies and nothing faults.
// [R18] Software can read the total region count.
// [R19] Overlapping enabled regions: highest region number decides.
// [R20] Sub-regions are ascending eighths starting at the region base.
`timescale 1ns/1ps
module rmp_unit
	import rmp_pkg::*;
#(
	parameter int NUM_REGIONS = RMP_NUM_REGIONS
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        ARST_N,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Access request from the core
	input  wire logic        ACC_VALID,
	input  wire logic [31:0] ACC_ADDR,
	input  wire logic        ACC_WRITE,
	input  wire logic        ACC_FETCH,
	input  wire logic        ACC_PRIV,
	input  wire logic        ACC_HFNMI,
	// Verdict
	output logic             CHK_VALID,
	output logic             CHK_FAULT,
	output logic             CHK_HIT,
	output logic      [2:0]  CHK_REGION
);

	// Region store
	logic [26:0] base_reg [NUM_REGIONS];
	logic [26:0] base_next[NUM_REGIONS];
	logic [4:0]  size_reg [NUM_REGIONS];
	logic [4:0]  size_next[NUM_REGIONS];
	logic [7:0]  srd_reg  [NUM_REGIONS];
	logic [7:0]  srd_next [NUM_REGIONS];
	logic [2:0]  ap_reg   [NUM_REGIONS];
	logic [2:0]  ap_next  [NUM_REGIONS];
	logic [NUM_REGIONS-1:0] xn_reg, xn_next;
	logic [NUM_REGIONS-1:0] ena_reg, ena_next;
	logic [NUM_REGIONS-1:0] hit_vec;

	// Control and status
	logic [2:0]  ctrl_reg, ctrl_next;
	logic [2:0]  rnr_reg, rnr_next;
	logic [4:0]  fstat_reg, fstat_next;
	logic [31:0] faddr_reg, faddr_next;

	// Bus state
	logic        wr_pend_reg, wr_pend_next;
	logic [7:0]  wr_ofs_reg, wr_ofs_next;
	logic        wr_map_reg, wr_map_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic        ap_take;

	// Verdict state
	logic        chk_valid_reg, chk_fault_reg, chk_hit_reg;
	logic [2:0]  chk_region_reg;
	logic        chk_valid_next, chk_fault_next, chk_hit_next;
	logic [2:0]  chk_region_next;

	// Decision terms
	logic        win_hit;
	logic [2:0]  win_idx;
	logic        bypass;
	logic        fault;
	logic        perm_ok;
	logic [2:0]  win_ap;

	// One matcher per region [R01]
	genvar g;
	generate
		for (g = 0; g < NUM_REGIONS; g++) begin : gen_region
			rmp_match_if mif ();
			assign mif.addr      = ACC_ADDR;
			assign mif.base      = base_reg[g];
			assign mif.size_code = size_reg[g];
			assign mif.srd       = srd_reg[g];
			assign mif.enable    = ena_reg[g];
			assign hit_vec[g]    = mif.hit;
			rmp_region_match u_match (
				.m (mif.region)
			);
		end
	endgenerate

	// Priority pick and permission check
	always_comb begin
		win_hit = 1'b0;
		win_idx = 3'h0;
		// Later regions override earlier ones [R19]
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit_vec[i]) begin
				win_hit = 1'b1;
				win_idx = 3'(i);
			end
		end
		win_ap = ap_reg[win_idx];
		// Data permission per mode; a fetch needs read permission [R05]
		case (win_ap)
			AP_PRW:            perm_ok = ACC_PRIV;
			AP_PRW_URO:        perm_ok = ACC_PRIV || !ACC_WRITE;
			AP_RW:             perm_ok = 1'b1;
			AP_PRO:            perm_ok = ACC_PRIV && !ACC_WRITE;
			AP_RO, AP_RO_ALT:  perm_ok = !ACC_WRITE;
			default:           perm_ok = 1'b0;
		endcase
		// Off, or in a handler that skips the regions: default map [R17] [R13] [R14]
		bypass = !ctrl_reg[CTRL_ENABLE_BIT] || (ACC_HFNMI && !ctrl_reg[CTRL_HFNMI_BIT]);
		if (bypass) begin
			fault = 1'b0;
		end else if (win_hit) begin
			fault = !perm_ok || (ACC_FETCH && xn_reg[win_idx]); // [R07] [R04]
		end else begin
			fault = !(ACC_PRIV && ctrl_reg[CTRL_PRIVDEF_BIT]); // [R11] [R12]
		end
	end

	// Verdict next values
	always_comb begin
		chk_valid_next  = ACC_VALID;
		chk_fault_next  = ACC_VALID && fault;
		chk_hit_next    = ACC_VALID && win_hit;
		chk_region_next = ACC_VALID ? win_idx : 3'h0;
	end

	// Verdict registers
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			chk_valid_reg  <= 1'b0;
			chk_fault_reg  <= 1'b0;
			chk_hit_reg    <= 1'b0;
			chk_region_reg <= 3'h0;
		end else begin
			chk_valid_reg  <= chk_valid_next;
			chk_fault_reg  <= chk_fault_next;
			chk_hit_reg    <= chk_hit_next;
			chk_region_reg <= chk_region_next;
		end
	end

	// Bus address phase capture and read data
	always_comb begin
		ap_take      = HSEL && HTRANS[1] && HREADY;
		wr_pend_next = ap_take && HWRITE;
		wr_ofs_next  = ap_take ? HADDR[7:0] : wr_ofs_reg;
		wr_map_next  = ap_take && (HADDR[31:8] == 24'h000000);
		hrdata_next  = 32'h00000000;
		// Unmapped or write phases read as zero
		if (ap_take && !HWRITE && (HADDR[31:8] == 24'h000000)) begin
			case (HADDR[7:0])
				OFS_TYPE:  hrdata_next[TYPE_COUNT_LSB +: 8] = 8'(NUM_REGIONS); // [R18]
				OFS_CTRL:  hrdata_next[2:0] = ctrl_reg;
				OFS_RNR:   hrdata_next[2:0] = rnr_reg;
				OFS_RBAR:  hrdata_next[31:RBAR_BASE_LSB] = base_reg[rnr_reg];
				OFS_RASR: begin
					// Enable returned with the rest so a saved word restores it [R10]
					hrdata_next[RASR_ENABLE_BIT]        = ena_reg[rnr_reg];
					hrdata_next[RASR_SIZE_LSB +: 5]     = size_reg[rnr_reg];
					hrdata_next[RASR_SRD_LSB +: 8]      = srd_reg[rnr_reg];
					hrdata_next[RASR_AP_LSB +: 3]       = ap_reg[rnr_reg];
					hrdata_next[RASR_XN_BIT]            = xn_reg[rnr_reg];
				end
				OFS_FSTAT: hrdata_next[4:0] = fstat_reg;
				OFS_FADDR: hrdata_next = faddr_reg;
				OFS_RENA:  hrdata_next[NUM_REGIONS-1:0] = ena_reg;
				default:   hrdata_next = 32'h00000000;
			endcase
		end
	end

	// Register writes and fault capture
	always_comb begin
		ctrl_next  = ctrl_reg;
		rnr_next   = rnr_reg;
		base_next  = base_reg;
		size_next  = size_reg;
		srd_next   = srd_reg;
		ap_next    = ap_reg;
		xn_next    = xn_reg;
		ena_next   = ena_reg;
		fstat_next = fstat_reg;
		faddr_next = faddr_reg;
		if (wr_pend_reg && wr_map_reg) begin
			case (wr_ofs_reg)
				OFS_CTRL: ctrl_next = HWDATA[2:0]; // [R14]
				OFS_RNR:  rnr_next  = HWDATA[2:0];
				OFS_RBAR: base_next[rnr_reg] = HWDATA[31:RBAR_BASE_LSB];
				OFS_RASR: begin
					// Enable written together with the attributes [R09]
					ena_next[rnr_reg]  = HWDATA[RASR_ENABLE_BIT];
					size_next[rnr_reg] = HWDATA[RASR_SIZE_LSB +: 5];
					srd_next[rnr_reg]  = HWDATA[RASR_SRD_LSB +: 8];
					ap_next[rnr_reg]   = HWDATA[RASR_AP_LSB +: 3];
					xn_next[rnr_reg]   = HWDATA[RASR_XN_BIT];
				end
				// Enables alone; other fields stay untouched [R08]
				OFS_RENA: ena_next = HWDATA[NUM_REGIONS-1:0];
				// Write one to clear the fault record
				OFS_FSTAT: fstat_next = fstat_reg & ~HWDATA[4:0];
				default: fstat_next = fstat_reg;
			endcase
		end
		// A new fault wins over a clear in the same cycle
		if (ACC_VALID && fault) begin
			fstat_next = {!win_hit, ACC_PRIV, ACC_WRITE, ACC_FETCH, 1'b1};
			faddr_next = ACC_ADDR;
		end
	end

	// Configuration, status and bus registers
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_reg    <= CTRL_RESET;
			rnr_reg     <= 3'h0;
			base_reg    <= '{default: BASE_RESET};
			size_reg    <= '{default: SIZE_RESET};
			srd_reg     <= '{default: SRD_RESET};
			ap_reg      <= '{default: AP_RESET};
			xn_reg      <= '0;
			ena_reg     <= '0;
			fstat_reg   <= 5'h00;
			faddr_reg   <= 32'h00000000;
			wr_pend_reg <= 1'b0;
			wr_ofs_reg  <= 8'h00;
			wr_map_reg  <= 1'b0;
			hrdata_reg  <= 32'h00000000;
		end else begin
			ctrl_reg    <= ctrl_next;
			rnr_reg     <= rnr_next;
			base_reg    <= base_next;
			size_reg    <= size_next;
			srd_reg     <= srd_next;
			ap_reg      <= ap_next;
			xn_reg      <= xn_next;
			ena_reg     <= ena_next;
			fstat_reg   <= fstat_next;
			faddr_reg   <= faddr_next;
			wr_pend_reg <= wr_pend_next;
			wr_ofs_reg  <= wr_ofs_next;
			wr_map_reg  <= wr_map_next;
			hrdata_reg  <= hrdata_next;
		end
	end

	// Outputs; bus never stalls and never errors
	assign HRDATA     = hrdata_reg;
	assign HREADYOUT  = 1'b1;
	assign HRESP      = 1'b0;
	assign CHK_VALID  = chk_valid_reg;
	assign CHK_FAULT  = chk_fault_reg;
	assign CHK_HIT    = chk_hit_reg;
	assign CHK_REGION = chk_region_reg;

	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	a_off_no_fault: assert property (ACC_VALID && !ctrl_reg[CTRL_ENABLE_BIT] |=> !CHK_FAULT) // [R17]
		else $error("fault raised while protection off");
	a_nohit_faults: assert property (ACC_VALID && ctrl_reg[CTRL_ENABLE_BIT] && !ACC_HFNMI // [R12]
		&& (hit_vec == '0) && !(ACC_PRIV && ctrl_reg[CTRL_PRIVDEF_BIT])
		|=> CHK_FAULT && !CHK_HIT)
		else $error("uncovered access did not fault");
	a_privdef_pass: assert property (ACC_VALID && ACC_PRIV && ctrl_reg[CTRL_PRIVDEF_BIT] // [R11]
		&& (hit_vec == '0) |=> !CHK_FAULT)
		else $error("privileged default map not applied");
	a_hfnmi_bypass: assert property (ACC_VALID && ACC_HFNMI && !ctrl_reg[CTRL_HFNMI_BIT] // [R13]
		|=> !CHK_FAULT)
		else $error("handler access not bypassed");
	a_xn_fetch: assert property (ACC_VALID && ACC_FETCH && ctrl_reg[CTRL_ENABLE_BIT] // [R04]
		&& !ACC_HFNMI && hit_vec[NUM_REGIONS-1] && xn_reg[NUM_REGIONS-1]
		|=> CHK_FAULT && CHK_REGION == 3'(NUM_REGIONS-1))
		else $error("fetch from no-execute region passed");
	a_top_region: assert property (ACC_VALID && hit_vec[NUM_REGIONS-1] // [R19]
		|=> CHK_HIT && CHK_REGION == 3'(NUM_REGIONS-1))
		else $error("highest region did not win");
	a_user_none: assert property (ACC_VALID && !ACC_PRIV && ctrl_reg[CTRL_ENABLE_BIT] // [R05] [R07]
		&& !ACC_HFNMI && win_hit && win_ap == AP_NONE |=> CHK_FAULT)
		else $error("user access to no-access region passed");
	a_rena_keeps: assert property (wr_pend_reg && wr_map_reg && wr_ofs_reg == OFS_RENA // [R08]
		|=> size_reg[0] == $past(size_reg[0]) && srd_reg[0] == $past(srd_reg[0]))
		else $error("enable write disturbed region settings");
	a_rasr_enable: assert property (wr_pend_reg && wr_map_reg // [R09] [R10]
		&& wr_ofs_reg == OFS_RASR ##2 ap_take && !HWRITE
		&& HADDR == {24'h000000, OFS_RASR} |=> HRDATA[RASR_ENABLE_BIT] == ena_reg[rnr_reg])
		else $error("region enable readback wrong");
	a_count_read: assert property (ap_take && !HWRITE && HADDR == {24'h000000, OFS_TYPE} // [R18]
		|=> HRDATA[TYPE_COUNT_LSB +: 8] == 8'(NUM_REGIONS))
		else $error("region count readback wrong");
	a_fault_sticky: assert property (CHK_FAULT |-> fstat_reg[FSTAT_VALID_BIT] // [R07]
		&& faddr_reg == $past(ACC_ADDR))
		else $error("fault not recorded");
	// Offset arithmetic kept apart from the matcher's own decode, so both must agree [R20]
	a_srd_blocks: assert property (ACC_VALID && ena_reg[0] && size_reg[0] >= SIZE_MIN_CODE // [R06]
		&& ((ACC_ADDR - {base_reg[0], 5'h00}) >> (6'(size_reg[0]) + 6'h01)) == 32'h00000000
		&& srd_reg[0][3'((ACC_ADDR - {base_reg[0], 5'h00}) >> (size_reg[0] - 5'h02))]
		|-> !hit_vec[0])
		else $error("disabled sub-region still hit");

	c_fault:   cover property (CHK_VALID && CHK_FAULT);
	c_hit_ok:  cover property (CHK_VALID && CHK_HIT && !CHK_FAULT);
	c_privdef: cover property (CHK_VALID && !CHK_HIT && !CHK_FAULT && ctrl_reg[0]);
	c_clear:   cover property (fstat_reg[0] ##1 !fstat_reg[0]);

endmodule

// ===== verification/rmp_core_model.sv
// Purpose: Core-side model that issues one access and collects the verdict
// Assumes: Verdict pulse stands in the cycle after the taking edge
// Notes:   Address flips when idle so a stale value is never trusted
`timescale 1ns/1ps
module rmp_core_model (
	// Clock
	input  wire logic        clk,
	// Access request
	output logic             acc_valid,
	output logic      [31:0] acc_addr,
	output logic             acc_write,
	output logic             acc_fetch,
	output logic             acc_priv,
	output logic             acc_hfnmi,
	// Verdict
	input  wire logic        chk_valid,
	input  wire logic        chk_fault,
	input  wire logic        chk_hit,
	input  wire logic [2:0]  chk_region
);
	// Idle request at time zero
	initial begin
		acc_valid = 1'b0;
		acc_addr = 32'h0;
		{acc_write, acc_fetch, acc_priv, acc_hfnmi} = 4'h0;
	end

	// One access; k is {write, fetch, priv, handler}, verdict read mid-cycle
	task automatic access(input logic [31:0] a, input logic [3:0] k, output logic [5:0] v);
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_addr <= a;
		{acc_write, acc_fetch, acc_priv, acc_hfnmi} <= k;
		@(posedge clk);
		acc_valid <= 1'b0;
		acc_addr <= ~a;
		@(negedge clk);
		v = {chk_valid, chk_fault, chk_hit, chk_region};
	endtask
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench for the region protection checker
// Assumes: Slave answers without wait states but the master still waits
// Notes:   Verdicts are compared as {fault, hit, region}
`timescale 1ns/1ps
module tb import rmp_pkg::*; ();
	// Access kinds {write, fetch, priv, handler}
	localparam logic [3:0] K_PR = 4'h2;
	localparam logic [3:0] K_PW = 4'hA;
	localparam logic [3:0] K_UR = 4'h0;
	localparam logic [3:0] K_UW = 4'h8;
	localparam logic [3:0] K_PF = 4'h6;
	localparam logic [3:0] K_HR = 4'h3;
	localparam logic [3:0] KINDS [4] = '{K_PR, K_PW, K_UR, K_UW};
	// Fault nibble {PR, PW, UR, UW} per permission code, code 7 in the top nibble
	localparam logic [31:0] AP_FAULTS = 32'h557F013F;
	// Expected verdicts {fault, hit, region}
	localparam logic [4:0] V_OK   = 5'h00;
	localparam logic [4:0] V_MISS = 5'h10;
	localparam logic [4:0] V_R0   = 5'h08;
	localparam logic [4:0] V_R7   = 5'h0F;
	localparam logic [4:0] V_R7F  = 5'h1F;

	logic        clock;
	logic        arst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        acc_valid;
	logic [31:0] acc_addr;
	logic        acc_write;
	logic        acc_fetch;
	logic        acc_priv;
	logic        acc_hfnmi;
	logic        chk_valid;
	logic        chk_fault;
	logic        chk_hit;
	logic [2:0]  chk_region;
	int          fail_count;
	int          samples_checked;
	int          cycles;

	rmp_unit dut (.CLOCK(clock), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr),
		.ACC_WRITE(acc_write), .ACC_FETCH(acc_fetch), .ACC_PRIV(acc_priv),
		.ACC_HFNMI(acc_hfnmi), .CHK_VALID(chk_valid), .CHK_FAULT(chk_fault),
		.CHK_HIT(chk_hit), .CHK_REGION(chk_region));

	rmp_core_model core (.clk(clock), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.acc_write(acc_write), .acc_fetch(acc_fetch), .acc_priv(acc_priv),
		.acc_hfnmi(acc_hfnmi), .chk_valid(chk_valid), .chk_fault(chk_fault),
		.chk_hit(chk_hit), .chk_region(chk_region));

	// Clock at 200 MHz
	always #2.5 clock = ~clock;

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One single transfer; ready and read data are taken at the rising edge, before it updates them
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		logic rdy;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin
			@(posedge clock);
			rdy = hreadyout;
		end while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clock);
			rdy = hreadyout;
			rd = hrdata;
		end while (rdy !== 1'b1);
		hwdata <= ~wd;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus(a, 1'b1, d, unused);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(a, 1'b0, 32'h0, d);
		chk(what, d, exp);
	endtask

	// Attribute word {xn, ap, sub-region disables, size, enable}
	function automatic logic [31:0] attr(logic en, logic [4:0] sz, logic [7:0] srd,
		logic [2:0] ap, logic xn);
		return {3'h0, xn, 1'b0, ap, 8'h0, srd, 2'h0, sz, en};
	endfunction

	// Disable first so no access sees a half-written region
	task automatic prog(input logic [2:0] r, input logic [31:0] base, input logic [31:0] a);
		wr(OFS_RNR, {29'h0, r});
		wr(OFS_RASR, 32'h0);
		wr(OFS_RBAR, base);
		wr(OFS_RASR, a);
	endtask

	task automatic acc(input logic [31:0] a, input logic [3:0] k, input logic [4:0] e);
		logic [5:0] v;
		core.access(a, k, v);
		chk("verdict", {26'h0, v}, {26'h0, 1'b1, e});
	endtask

	task automatic t_reset();
		rdchk("count", OFS_TYPE, 32'(RMP_NUM_REGIONS) << TYPE_COUNT_LSB);
		rdchk("ctrl", OFS_CTRL, 32'h0);
		rdchk("attr", OFS_RASR, attr(1'b0, SIZE_RESET, SRD_RESET, AP_RESET, 1'b0));
		wr(8'h40, 32'hFFFFFFFF);
		rdchk("unmapped", 8'h40, 32'h0);
		acc(32'h00001234, K_UW, V_OK);
		$display("test reset done");
	endtask

	task automatic t_perm();
		prog(3'h0, 32'h00001000, attr(1'b1, 5'd11, 8'h00, AP_RW, 1'b1));
		wr(OFS_CTRL, 32'h1);
		acc(32'h00001000, K_PF, 5'h18);
		wr(OFS_RASR, attr(1'b1, 5'd11, 8'h00, AP_RW, 1'b0));
		acc(32'h00001FFC, K_PF, V_R0);
		acc(32'h00002000, K_PR, V_MISS);
		for (int ap = 0; ap < 8; ap++) begin
			wr(OFS_RASR, attr(1'b1, 5'd11, 8'h00, 3'(ap), 1'b0));
			for (int j = 0; j < 4; j++) begin
				acc(32'h00001100, KINDS[j], {AP_FAULTS[ap * 4 + 3 - j], 4'h8});
			end
		end
		$display("test permissions done");
	endtask

	task automatic t_sub();
		wr(OFS_RASR, attr(1'b1, 5'd11, 8'h04, AP_RW, 1'b0));
		acc(32'h000013FC, K_UW, V_R0);
		acc(32'h00001400, K_UW, V_MISS);
		acc(32'h000015FC, K_UR, V_MISS);
		acc(32'h00001600, K_UW, V_R0);
		$display("test sub-regions done");
	endtask

	task automatic t_overlap();
		prog(3'h7, 32'h00000000, attr(1'b1, 5'd31, 8'h00, AP_RO, 1'b0));
		acc(32'h00001000, K_UW, V_R7F);
		acc(32'h00001000, K_UR, V_R7);
		acc(32'h00001400, K_UR, V_R7);
		acc(32'hFFFFFFF0, K_UR, V_R7);
		$display("test overlap done");
	endtask

	task automatic t_disable();
		wr(OFS_RENA, 32'h1);
		acc(32'h00001000, K_UW, V_R0);
		rdchk("saved", OFS_RASR, attr(1'b0, 5'd31, 8'h00, AP_RO, 1'b0));
		wr(OFS_RASR, attr(1'b1, 5'd31, 8'h00, AP_RO, 1'b1));
		rdchk("restored", OFS_RASR, attr(1'b1, 5'd31, 8'h00, AP_RO, 1'b1));
		acc(32'h00001000, K_UW, V_R7F);
		acc(32'h00001000, K_PF, V_R7F);
		$display("test region disable done");
	endtask

	task automatic t_global();
		wr(OFS_RENA, 32'h0);
		acc(32'h00001000, K_PR, V_MISS);
		acc(32'h00001000, K_HR, V_OK);
		wr(OFS_CTRL, 32'h5);
		acc(32'h00001000, K_PR, V_OK);
		acc(32'h00001000, K_UR, V_MISS);
		wr(OFS_CTRL, 32'h3);
		acc(32'h00001000, K_HR, V_MISS);
		// Fault record of the uncovered privileged handler read, then write-one-to-clear
		rdchk("fstat", OFS_FSTAT, 32'(1 << FSTAT_NOHIT_BIT | 1 << FSTAT_PRIV_BIT | 1 << FSTAT_VALID_BIT));
		rdchk("faddr", OFS_FADDR, 32'h00001000);
		wr(OFS_FSTAT, 32'h0000001F);
		rdchk("cleared", OFS_FSTAT, 32'h00000000);
		wr(OFS_CTRL, 32'h0);
		acc(32'h00001000, K_UW, V_OK);
		$display("test global options done");
	endtask

	// Reset for five cycles, then the scenarios in order
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		t_reset();
		t_perm();
		t_sub();
		t_overlap();
		t_disable();
		t_global();
		wrap_up();
	end
endmodule
